/* logic/tpg_pkg.sv */
//------------------------------------------------------------------------------
// Purpose: constants and types for the timing pulse output gate
//------------------------------------------------------------------------------
// Assumes: 50 MHz core clock, register port with one-cycle read latency
// Notes:   staging word offsets mirror the binary command record with header 0
//
// What this block does
// - enable code 0 keeps the pulse output off, no pulses generated.
// - code 1 enables always and is default; code 2 waits for steered time status.
// - code 3 waits for steered status, then for the next whole-minute boundary.
// - polarity 0 gives negative pulses, 1 positive; negative is default.
// - pulses repeat at a programmable period from 0.05 s up to about 20 s.
// - defaults are enabled, negative, 1.0 s period, 1000 us width, zero limit.
// - width is in microseconds; the configuring party keeps it within half the period.
// - limit of 0..2147483647 ns gates output on clock offset magnitude.
// - a zero limit turns the clock-offset gating off completely.
// - basic and extended commands write one shared set of settings.
// - record fields sit at H, H+4, H+8, H+16 and H+20 after the header.
// - the leading edge is the reference; negative idles high, positive idles low.
//------------------------------------------------------------------------------
package tpg_pkg;

	//--------------------------------------------------------------------------
	// register map
	//--------------------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_STAGE_ENABLE = 8'h00;
	localparam logic [7:0] REG_STAGE_POLARITY = 8'h04;
	localparam logic [7:0] REG_STAGE_PERIOD = 8'h08;
	localparam logic [7:0] REG_STAGE_WIDTH = 8'h10;
	localparam logic [7:0] REG_STAGE_LIMIT = 8'h14;
	localparam logic [7:0] REG_COMMIT = 8'h18;
	localparam logic [7:0] REG_ACT_ENABLE = 8'h20;
	localparam logic [7:0] REG_ACT_POLARITY = 8'h24;
	localparam logic [7:0] REG_ACT_PERIOD = 8'h28;
	localparam logic [7:0] REG_ACT_WIDTH = 8'h2c;
	localparam logic [7:0] REG_ACT_LIMIT = 8'h30;
	localparam logic [7:0] REG_STATUS = 8'h34;

	// commit word layout: bit 0 selects extended, bits 3:1 count given fields
	localparam int COMMIT_EXT_BIT = 0;
	localparam int COMMIT_CNT_LSB = 1;
	localparam int COMMIT_CNT_W = 3;
	localparam logic [2:0] FIELDS_BASIC = 3'h4;
	localparam logic [2:0] FIELDS_EXT = 3'h5;

	// status word bit positions
	localparam int ST_GATE_BIT = 0;
	localparam int ST_OFFSET_OK_BIT = 1;
	localparam int ST_STATE_LSB = 2;
	localparam int ST_REJECT_BIT = 4;
	localparam int ST_PULSE_BIT = 5;

	//--------------------------------------------------------------------------
	// codes and settings
	//--------------------------------------------------------------------------
	typedef enum logic [1:0] {
		EN_OFF = 2'h0,
		EN_ON = 2'h1,
		EN_AFTER_LOCK = 2'h2,
		EN_AFTER_LOCK_MINUTE_ALIGNED = 2'h3
	} tpg_enable_e;

	localparam logic POL_NEGATIVE = 1'b0;
	localparam logic POL_POSITIVE = 1'b1;

	typedef struct packed {
		tpg_enable_e enable;
		logic polarity;
		logic [31:0] period_us;
		logic [31:0] width_us;
		logic [31:0] limit_ns;
	} tpg_cfg_s;

	localparam logic [31:0] DEF_PERIOD_US = 32'h000f4240; // 1.0 s
	localparam logic [31:0] DEF_WIDTH_US = 32'h000003e8; // 1000 us
	localparam logic [31:0] DEF_LIMIT_NS = 32'h00000000;
	localparam logic [31:0] MIN_PERIOD_US = 32'h0000c350; // 0.05 s
	localparam logic [31:0] MAX_PERIOD_US = 32'h01312d00; // 20 s
	localparam tpg_cfg_s CFG_DEFAULT = '{EN_ON, POL_NEGATIVE, DEF_PERIOD_US,
		DEF_WIDTH_US, DEF_LIMIT_NS};

	//--------------------------------------------------------------------------
	// timing
	//--------------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int MICROSECOND_NS = 1000;
	localparam int CYCLES_PER_US = MICROSECOND_NS / CLK_PERIOD_NS;

endpackage

/* logic/tpg_pulse_gate.sv */
//------------------------------------------------------------------------------
// Purpose: periodic timing pulse generator with enable and clock offset gating
//------------------------------------------------------------------------------
// Assumes: time status, minute boundary and offset inputs synchronous to core_clk
// Notes:   period is held as whole microseconds rather than a floating value
//------------------------------------------------------------------------------
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ns

module tpg_pulse_gate (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// register port
	input wire logic [tpg_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	// receiver time base
	input wire logic steered_time_status,
	input wire logic minute_boundary,
	input wire logic signed [31:0] clock_offset_ns,
	// pulse pin and status
	output logic pulse_out,
	output logic pulse_gate_open,
	output logic cmd_reject
);

	//--------------------------------------------------------------------------
	// declarations
	//--------------------------------------------------------------------------
	typedef enum logic [1:0] {
		G_IDLE = 2'b00,
		G_WAIT_LOCK = 2'b01,
		G_WAIT_MINUTE = 2'b11,
		G_RUN = 2'b10
	} tpg_gate_e;

	localparam logic [5:0] US_LAST = 6'(tpg_pkg::CYCLES_PER_US - 1);

	tpg_pkg::tpg_cfg_s cfg;
	tpg_pkg::tpg_cfg_s stage;
	tpg_pkg::tpg_cfg_s next_cfg;
	tpg_gate_e state;
	tpg_gate_e next_state;
	logic [31:0] stage_enable_raw;
	logic [31:0] stage_pol_raw;
	logic commit_req;
	logic commit_ext;
	logic [2:0] commit_cnt;
	logic commit_bad;
	logic cfg_load;
	logic enable_changed;
	logic [31:0] offset_mag;
	logic offset_ok;
	logic next_gate;
	logic gate_start;
	logic [5:0] us_div;
	logic us_tick;
	logic [31:0] period_cnt;
	logic pulse_active;
	logic idle_level;

	// true when the command carried field number idx (1-based)
	function automatic logic field_given(input logic [2:0] cnt, input logic [2:0] idx);
		field_given = (cnt >= idx);
	endfunction

	//--------------------------------------------------------------------------
	// staging registers, written field by field before a commit
	//--------------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			stage_enable_raw <= 32'(tpg_pkg::CFG_DEFAULT.enable);
			stage_pol_raw <= 32'(tpg_pkg::CFG_DEFAULT.polarity);
			stage.enable <= tpg_pkg::CFG_DEFAULT.enable;
			stage.polarity <= tpg_pkg::CFG_DEFAULT.polarity;
			stage.period_us <= tpg_pkg::DEF_PERIOD_US;
			stage.width_us <= tpg_pkg::DEF_WIDTH_US;
			stage.limit_ns <= tpg_pkg::DEF_LIMIT_NS;
		end else if (reg_write) begin
			unique case (reg_addr)
				// decoded copies sit beside the raw words, which feed the range checks
				tpg_pkg::REG_STAGE_ENABLE: begin
					stage_enable_raw <= reg_wdata;
					stage.enable <= tpg_pkg::tpg_enable_e'(reg_wdata[1:0]);
				end
				tpg_pkg::REG_STAGE_POLARITY: begin
					stage_pol_raw <= reg_wdata;
					stage.polarity <= reg_wdata[0];
				end
				tpg_pkg::REG_STAGE_PERIOD: stage.period_us <= reg_wdata;
				tpg_pkg::REG_STAGE_WIDTH: stage.width_us <= reg_wdata;
				tpg_pkg::REG_STAGE_LIMIT: stage.limit_ns <= reg_wdata;
				default: ;
			endcase
		end
	end

	//--------------------------------------------------------------------------
	// command commit: merge given fields, default the trailing ones
	//--------------------------------------------------------------------------
	assign commit_req = reg_write && (reg_addr == tpg_pkg::REG_COMMIT);
	assign commit_ext = reg_wdata[tpg_pkg::COMMIT_EXT_BIT];
	assign commit_cnt = reg_wdata[tpg_pkg::COMMIT_CNT_LSB +: tpg_pkg::COMMIT_CNT_W];

	// one shared settings image for both command kinds
	always_comb begin
		next_cfg = cfg;
		next_cfg.enable = field_given(commit_cnt, 3'h1) ? stage.enable
			: tpg_pkg::CFG_DEFAULT.enable;
		next_cfg.polarity = field_given(commit_cnt, 3'h2) ? stage.polarity
			: tpg_pkg::CFG_DEFAULT.polarity;
		next_cfg.period_us = field_given(commit_cnt, 3'h3) ? stage.period_us
			: tpg_pkg::DEF_PERIOD_US;
		next_cfg.width_us = field_given(commit_cnt, 3'h4) ? stage.width_us
			: tpg_pkg::DEF_WIDTH_US;
		if (commit_ext) begin
			next_cfg.limit_ns = field_given(commit_cnt, 3'h5) ? stage.limit_ns
				: tpg_pkg::DEF_LIMIT_NS;
		end
	end

	// reject malformed commands whole; nothing is half applied
	always_comb begin
		commit_bad = 1'b0;
		if (commit_cnt > (commit_ext ? tpg_pkg::FIELDS_EXT : tpg_pkg::FIELDS_BASIC))
			commit_bad = 1'b1;
		if (field_given(commit_cnt, 3'h1) && (stage_enable_raw[31:2] != 30'h0))
			commit_bad = 1'b1;
		if (field_given(commit_cnt, 3'h2) && (stage_pol_raw[31:1] != 31'h0))
			commit_bad = 1'b1;
		if (field_given(commit_cnt, 3'h3) && ((stage.period_us < tpg_pkg::MIN_PERIOD_US)
			|| (stage.period_us > tpg_pkg::MAX_PERIOD_US)))
			commit_bad = 1'b1;
		if (field_given(commit_cnt, 3'h4) && (stage.width_us == 32'h0))
			commit_bad = 1'b1;
		if (commit_ext && field_given(commit_cnt, 3'h5) && stage.limit_ns[31])
			commit_bad = 1'b1;
	end

	assign cfg_load = commit_req && !commit_bad;
	assign enable_changed = cfg_load && (next_cfg.enable != cfg.enable);

	// active settings start at the factory image
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cfg <= tpg_pkg::CFG_DEFAULT;
		end else if (cfg_load) begin
			cfg <= next_cfg;
		end
	end

	// sticky reject flag; a new reject wins over a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cmd_reject <= 1'b0;
		end else if (commit_req && commit_bad) begin
			cmd_reject <= 1'b1;
		end else if (reg_write && (reg_addr == tpg_pkg::REG_STATUS)
			&& reg_wdata[tpg_pkg::ST_REJECT_BIT]) begin
			cmd_reject <= 1'b0;
		end
	end

	//--------------------------------------------------------------------------
	// enable selector state machine
	//--------------------------------------------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			G_IDLE: begin
				if (cfg.enable == tpg_pkg::EN_ON)
					next_state = G_RUN;
				else if (cfg.enable != tpg_pkg::EN_OFF)
					next_state = G_WAIT_LOCK;
			end
			G_WAIT_LOCK: begin
				if (steered_time_status)
					next_state = (cfg.enable == tpg_pkg::EN_AFTER_LOCK_MINUTE_ALIGNED)
						? G_WAIT_MINUTE : G_RUN;
			end
			G_WAIT_MINUTE: begin
				if (minute_boundary)
					next_state = G_RUN;
			end
			G_RUN: ;
		endcase
		// a new selector code re-arms the wait from scratch
		if (enable_changed || (cfg.enable == tpg_pkg::EN_OFF))
			next_state = G_IDLE;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state <= G_IDLE;
		end else begin
			state <= next_state;
		end
	end

	//--------------------------------------------------------------------------
	// clock offset bound
	//--------------------------------------------------------------------------
	// magnitude of the most negative offset still fits 32 unsigned bits
	assign offset_mag = clock_offset_ns[31] ? 32'(-clock_offset_ns) : clock_offset_ns;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			offset_ok <= 1'b1;
		end else begin
			offset_ok <= (cfg.limit_ns == 32'h0) || (offset_mag <= cfg.limit_ns);
		end
	end

	//--------------------------------------------------------------------------
	// gate and pulse timing
	//--------------------------------------------------------------------------
	assign next_gate = (state == G_RUN) && offset_ok;
	assign gate_start = next_gate && !pulse_gate_open;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			pulse_gate_open <= 1'b0;
		end else begin
			pulse_gate_open <= next_gate;
		end
	end

	// microsecond enable; restarts with the gate so the first edge lands at once
	always_ff @(posedge core_clk) begin
		if (reset || gate_start) begin
			us_div <= 6'h0;
		end else begin
			us_div <= (us_div == US_LAST) ? 6'h0 : 6'(us_div + 6'h1);
		end
	end

	assign us_tick = (us_div == US_LAST);

	// period counter in microseconds; phase zero is the leading edge
	always_ff @(posedge core_clk) begin
		if (reset || gate_start) begin
			period_cnt <= 32'h0;
		end else if (us_tick) begin
			if (period_cnt >= 32'(cfg.period_us - 32'h1))
				period_cnt <= 32'h0;
			else
				period_cnt <= 32'(period_cnt + 32'h1);
		end
	end

	// width past half the period is the writer's concern; a width at or
	// above the period simply yields a constant active level
	assign pulse_active = pulse_gate_open && (period_cnt < cfg.width_us);
	assign idle_level = (cfg.polarity == tpg_pkg::POL_NEGATIVE);

	// gated off means resting at idle, never mid-pulse
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pulse_out <= 1'b1;
		end else begin
			pulse_out <= pulse_active ? !idle_level : idle_level;
		end
	end

	//--------------------------------------------------------------------------
	// register read port, data one cycle after the strobe
	//--------------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			reg_rdata <= 32'h0;
		end else if (reg_read) begin
			unique case (reg_addr)
				tpg_pkg::REG_STAGE_ENABLE: reg_rdata <= stage_enable_raw;
				tpg_pkg::REG_STAGE_POLARITY: reg_rdata <= stage_pol_raw;
				tpg_pkg::REG_STAGE_PERIOD: reg_rdata <= stage.period_us;
				tpg_pkg::REG_STAGE_WIDTH: reg_rdata <= stage.width_us;
				tpg_pkg::REG_STAGE_LIMIT: reg_rdata <= stage.limit_ns;
				tpg_pkg::REG_ACT_ENABLE: reg_rdata <= {30'h0, cfg.enable};
				tpg_pkg::REG_ACT_POLARITY: reg_rdata <= {31'h0, cfg.polarity};
				tpg_pkg::REG_ACT_PERIOD: reg_rdata <= cfg.period_us;
				tpg_pkg::REG_ACT_WIDTH: reg_rdata <= cfg.width_us;
				tpg_pkg::REG_ACT_LIMIT: reg_rdata <= cfg.limit_ns;
				tpg_pkg::REG_STATUS: begin
					reg_rdata <= 32'h0;
					reg_rdata[tpg_pkg::ST_GATE_BIT] <= pulse_gate_open;
					reg_rdata[tpg_pkg::ST_OFFSET_OK_BIT] <= offset_ok;
					reg_rdata[tpg_pkg::ST_STATE_LSB +: 2] <= state;
					reg_rdata[tpg_pkg::ST_REJECT_BIT] <= cmd_reject;
					reg_rdata[tpg_pkg::ST_PULSE_BIT] <= pulse_out;
				end
				default: reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end

	//--------------------------------------------------------------------------
	// assertions
	//--------------------------------------------------------------------------
	a_off_stays_idle: assert property (@(posedge core_clk) disable iff (reset)
		(cfg.enable == tpg_pkg::EN_OFF && !cfg_load)[*4] |-> (pulse_out == idle_level))
		else $error("pulse pin left idle while selector is off");

	a_lock_wait_holds: assert property (@(posedge core_clk) disable iff (reset)
		(state == G_WAIT_LOCK && !steered_time_status) |=> (state != G_RUN))
		else $error("gate opened before steered time status");

	a_minute_wait_holds: assert property (@(posedge core_clk) disable iff (reset)
		(state == G_WAIT_MINUTE && !minute_boundary && !cfg_load
		&& cfg.enable == tpg_pkg::EN_AFTER_LOCK_MINUTE_ALIGNED) |=> (state == G_WAIT_MINUTE))
		else $error("minute-aligned wait left without a boundary");

	a_gate_closed_idle: assert property (@(posedge core_clk) disable iff (reset)
		!pulse_gate_open |=> (pulse_out == $past(idle_level)))
		else $error("pulse pin active while gate closed");

	a_reset_defaults: assert property (@(posedge core_clk)
		$past(reset) && !reset |-> (cfg == tpg_pkg::CFG_DEFAULT && pulse_out == 1'b1))
		else $error("settings differ from factory image after reset");

	a_limit_blocks: assert property (@(posedge core_clk) disable iff (reset)
		(cfg.limit_ns != 32'h0 && offset_mag > cfg.limit_ns) |=> ##1 !pulse_gate_open)
		else $error("gate open with offset beyond limit");

	a_limit_zero_free: assert property (@(posedge core_clk) disable iff (reset)
		(cfg.limit_ns == 32'h0) |=> offset_ok)
		else $error("zero limit still gated output");

	a_leading_edge: assert property (@(posedge core_clk) disable iff (reset)
		($rose(pulse_gate_open) && cfg.width_us != 32'h0 && !$past(cfg_load))
		|=> (pulse_out == !$past(idle_level)))
		else $error("first pulse edge missing at gate opening");

	a_shared_field: assert property (@(posedge core_clk) disable iff (reset)
		(cfg_load && !commit_ext && commit_cnt >= 3'h2) |=> (cfg.polarity == $past(stage.polarity)))
		else $error("basic command did not update shared polarity");

	a_trailing_default: assert property (@(posedge core_clk) disable iff (reset)
		(cfg_load && commit_cnt <= 3'h2) |=> (cfg.width_us == tpg_pkg::DEF_WIDTH_US
		&& cfg.period_us == tpg_pkg::DEF_PERIOD_US))
		else $error("omitted trailing field kept an old value");

	a_reject_keeps: assert property (@(posedge core_clk) disable iff (reset)
		(commit_req && commit_bad) |=> ($stable(cfg) && cmd_reject))
		else $error("rejected command changed settings");

endmodule

/* dv/tpg_trigger_model.sv */
// Purpose: external equipment triggered by the timing pulse leading edge
// Assumes: pin sampled on core_clk; expected active level given by the bench
// Notes:   a passive listener, it drives nothing back toward the block
`timescale 1ns/1ns

module tpg_trigger_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// pulse pin and its expected sense
	input wire logic pulse_out,
	input wire logic active_level,
	// trigger results
	output int edge_count,
	output int last_width
);
	logic prev_pin;
	int run_len;

	// count leading edges; a pulse length is only known once the pin goes idle
	always_ff @(posedge core_clk) begin
		prev_pin <= pulse_out;
		if (reset) begin
			edge_count <= 0;
			run_len <= 0;
			last_width <= 0;
		end else if (pulse_out === active_level) begin
			if (prev_pin !== active_level) begin
				edge_count <= edge_count + 1;
				run_len <= 1;
			end else begin
				run_len <= run_len + 1;
			end
		end else if (run_len != 0) begin
			last_width <= run_len;
			run_len <= 0;
		end
	end
endmodule

/* dv/timing_pulse_output_gate_bench.sv */
// Purpose: self-checking bench for the timing pulse output gate
// Assumes: 50 MHz clock; commits staged with the full extended record, except the basic ones in t_basic and t_reject
// Notes:   full periods are millions of cycles, so only the first pulse is timed
`timescale 1ns/1ns

module timing_pulse_output_gate_bench;
	logic core_clk;
	logic reset;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_write;
	logic reg_read;
	logic [31:0] reg_rdata;
	logic steered_time_status;
	logic minute_boundary;
	logic signed [31:0] clock_offset_ns;
	logic pulse_out;
	logic pulse_gate_open;
	logic cmd_reject;
	logic exp_pol;
	int trig_edges;
	int trig_width;
	int num_errors;
	int checks;
	int cyc;
	localparam logic [31:0] EXT5 = 32'h0000000b;

	tpg_pulse_gate dut_u (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .steered_time_status(steered_time_status),
		.minute_boundary(minute_boundary), .clock_offset_ns(clock_offset_ns),
		.pulse_out(pulse_out), .pulse_gate_open(pulse_gate_open), .cmd_reject(cmd_reject));

	tpg_trigger_model trig_u (.core_clk(core_clk), .reset(reset), .pulse_out(pulse_out),
		.active_level(exp_pol), .edge_count(trig_edges), .last_width(trig_width));

	//--------------------------------------------------------------------------
	// shared tasks
	//--------------------------------------------------------------------------
	task automatic chk(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("ERROR %0t: %s", $time, msg);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string msg);
		@(posedge core_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1;
		chk(reg_rdata === e, msg);
	endtask

	// stage the record fields in order, then commit
	task automatic cfg(input logic [31:0] en, pol, per, wid, lim, cmd);
		wr(tpg_pkg::REG_STAGE_ENABLE, en);
		wr(tpg_pkg::REG_STAGE_POLARITY, pol);
		wr(tpg_pkg::REG_STAGE_PERIOD, per);
		wr(tpg_pkg::REG_STAGE_WIDTH, wid);
		wr(tpg_pkg::REG_STAGE_LIMIT, lim);
		wr(tpg_pkg::REG_COMMIT, cmd);
	endtask

	task automatic wait_gate(input logic lvl, input int n, input string msg);
		int i;
		#1;
		i = 0;
		while (pulse_gate_open !== lvl && i < n) begin
			@(posedge core_clk);
			#1;
			i++;
		end
		chk(pulse_gate_open === lvl, msg);
	endtask

	// settle past the gate latency, then the pin must rest idle throughout
	task automatic hold_off(input int n, input string msg);
		logic ok;
		ok = 1'b1;
		repeat (6) @(posedge core_clk);
		repeat (n) begin
			@(posedge core_clk);
			#1;
			if (pulse_gate_open !== 1'b0 || pulse_out !== ~exp_pol)
				ok = 1'b0;
		end
		chk(ok, msg);
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	//--------------------------------------------------------------------------
	// scenarios
	//--------------------------------------------------------------------------
	task automatic t_defaults;
		repeat (6) @(posedge core_clk);
		#1;
		chk(trig_edges === 1 && pulse_out === 1'b0, "first falling edge");
		rd(tpg_pkg::REG_ACT_ENABLE, 32'h1, "def enable");
		rd(tpg_pkg::REG_ACT_POLARITY, 32'h0, "def polarity");
		rd(tpg_pkg::REG_ACT_PERIOD, tpg_pkg::DEF_PERIOD_US, "def period");
		rd(tpg_pkg::REG_ACT_WIDTH, tpg_pkg::DEF_WIDTH_US, "def width");
		rd(tpg_pkg::REG_ACT_LIMIT, tpg_pkg::DEF_LIMIT_NS, "def limit");
	endtask

	task automatic t_off_then_width;
		int e0;
		exp_pol = 1'b1;
		cfg(0, 1, tpg_pkg::MIN_PERIOD_US, 10, 0, EXT5);
		hold_off(40, "code 0 not idle");
		e0 = trig_edges;
		cfg(1, 1, tpg_pkg::MIN_PERIOD_US, 10, 0, EXT5);
		wait_gate(1'b1, 8, "code 1 gate");
		repeat (520) @(posedge core_clk);
		#1;
		chk(trig_edges === e0 + 1, "one rising edge");
		chk(trig_width === 10 * tpg_pkg::CYCLES_PER_US, "pulse width");
	endtask

	task automatic t_lock_waits;
		cfg(2, 1, tpg_pkg::MIN_PERIOD_US, 10, 0, EXT5);
		hold_off(40, "code 2 early");
		@(posedge core_clk);
		steered_time_status <= 1'b1;
		wait_gate(1'b1, 6, "code 2 after lock");
		cfg(3, 1, tpg_pkg::MIN_PERIOD_US, 10, 0, EXT5);
		hold_off(40, "code 3 before minute");
		@(posedge core_clk);
		minute_boundary <= 1'b1;
		@(posedge core_clk);
		minute_boundary <= 1'b0;
		wait_gate(1'b1, 6, "code 3 at minute");
	endtask

	task automatic t_offset_limit;
		@(posedge core_clk);
		clock_offset_ns <= -32'sd100000;
		cfg(1, 1, tpg_pkg::MIN_PERIOD_US, 10, 0, EXT5);
		// the gate is still open from the old code; let the re-arm pass first
		repeat (4) @(posedge core_clk);
		wait_gate(1'b1, 8, "zero limit ignores offset");
		cfg(1, 1, tpg_pkg::MIN_PERIOD_US, 10, 100, EXT5);
		hold_off(20, "offset beyond limit");
		@(posedge core_clk);
		clock_offset_ns <= -32'sd100;
		wait_gate(1'b1, 6, "offset at bound");
		@(posedge core_clk);
		clock_offset_ns <= 32'sd101;
		wait_gate(1'b0, 4, "offset past bound");
		repeat (3) @(posedge core_clk);
		#1;
		chk(pulse_out === 1'b0, "pin idle while gated");
	endtask

	// basic commit of two fields: later fields default, limit untouched
	task automatic t_basic;
		wr(tpg_pkg::REG_STAGE_POLARITY, 32'h0);
		wr(tpg_pkg::REG_COMMIT, 32'h4);
		rd(tpg_pkg::REG_ACT_POLARITY, 32'h0, "shared polarity");
		rd(tpg_pkg::REG_ACT_WIDTH, tpg_pkg::DEF_WIDTH_US, "omitted width");
		rd(tpg_pkg::REG_ACT_PERIOD, tpg_pkg::DEF_PERIOD_US, "omitted period");
		rd(tpg_pkg::REG_ACT_LIMIT, 32'h64, "limit kept");
	endtask

	task automatic t_reject;
		cfg(1, 1, tpg_pkg::MIN_PERIOD_US - 1, 10, 100, EXT5);
		#1;
		chk(cmd_reject === 1'b1, "short period refused");
		rd(tpg_pkg::REG_ACT_PERIOD, tpg_pkg::DEF_PERIOD_US, "period kept");
		rd(tpg_pkg::REG_STAGE_PERIOD, tpg_pkg::MIN_PERIOD_US - 1, "staged period");
		// running, offset past its bound, reject pending, negative pin at rest
		rd(tpg_pkg::REG_STATUS, 32'h00000038, "status word");
		rd(8'h0c, 32'h0, "unmapped read");
		wr(tpg_pkg::REG_STATUS, 32'h10);
		#1;
		chk(cmd_reject === 1'b0, "reject cleared");
		// only the field count is wrong in this basic commit
		wr(tpg_pkg::REG_STAGE_PERIOD, tpg_pkg::MIN_PERIOD_US);
		wr(tpg_pkg::REG_COMMIT, 32'h0000000a);
		#1;
		chk(cmd_reject === 1'b1, "basic count over four refused");
	endtask

	//--------------------------------------------------------------------------
	// clock, watchdog and main sequence
	//--------------------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// a hang counts as a mismatch and still reaches the report
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			$display("ERROR %0t: timeout", $time);
			test_done;
		end
	end

	initial begin
		reset = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		steered_time_status = 1'b0;
		minute_boundary = 1'b0;
		clock_offset_ns = 32'sd0;
		exp_pol = 1'b0;
		num_errors = 0;
		checks = 0;
		cyc = 0;
		repeat (4) @(posedge core_clk);
		#1;
		chk(pulse_out === 1'b1 && pulse_gate_open === 1'b0, "reset idle");
		@(posedge core_clk);
		reset <= 1'b0;
		t_defaults;
		t_off_then_width;
		t_lock_waits;
		t_offset_limit;
		t_basic;
		t_reject;
		test_done;
	end
endmodule
